// file: common/clc_pkg.sv
// constants and types of the channel limit checker
// assumes one 125 MHz clock and a plain register port
package clc_pkg;
  localparam int NCH      = 4;
  localparam int ADDR_W   = 6;
  localparam int DATA_W   = 32;
  localparam int CODE_W   = 8;
  localparam int SAMPLE_W = 16;
  localparam int RANGE_W  = 3;
  localparam int TRIG_W   = 3;
  localparam int ERR_W    = 3;
  localparam int QUES_W   = 16;

  // register index, address is {index, channel}
  localparam logic [3:0] REG_LOWER_DATA = 4'h0;
  localparam logic [3:0] REG_UPPER_DATA = 4'h1;
  localparam logic [3:0] REG_LOWER_EN   = 4'h2;
  localparam logic [3:0] REG_UPPER_EN   = 4'h3;
  localparam logic [3:0] REG_FAIL       = 4'h4;
  localparam logic [3:0] REG_RANGE      = 4'h5;
  localparam logic [3:0] REG_LOWER_LIM  = 4'h6;
  localparam logic [3:0] REG_UPPER_LIM  = 4'h7;
  localparam logic [3:0] REG_ERROR      = 4'h8;
  localparam logic [3:0] REG_TRIG       = 4'h9;
  localparam logic [3:0] REG_QUES       = 4'ha;
  localparam logic [3:0] REG_QUES_MASK  = 4'hb;

  // limit codes in steps of the present range, step = full scale / 128
  localparam logic signed [CODE_W-1:0] LOWER_MIN   = 8'sh81;
  localparam logic signed [CODE_W-1:0] LOWER_MAX   = 8'sh7e;
  localparam logic signed [CODE_W-1:0] UPPER_MIN   = 8'sh81;
  localparam logic signed [CODE_W-1:0] UPPER_MAX   = 8'sh7f;
  localparam logic signed [CODE_W-1:0] LOWER_RESET = 8'sh81;
  localparam logic signed [CODE_W-1:0] UPPER_RESET = 8'sh7e;
  localparam int                       CODE_SHIFT  = 8;

  // write data option field
  localparam int         OPT_LSB   = 16;
  localparam logic [1:0] OPT_VALUE = 2'h0;
  localparam logic [1:0] OPT_MIN   = 2'h1;
  localparam logic [1:0] OPT_MAX   = 2'h2;

  localparam int ERR_BOUND    = 0;
  localparam int ERR_CONFLICT = 1;
  localparam int ERR_BUSY     = 2;

  localparam int QUES_LOWER_BIT = 9;
  localparam int QUES_UPPER_BIT = 10;

  localparam logic [RANGE_W-1:0] RANGE_RESET = 3'h6;
  localparam logic [TRIG_W-1:0]  TRIG_RESET  = 3'h0;
  localparam logic [QUES_W-1:0]  QUES_MASK_RESET = 16'h0000;

  typedef struct packed {
    logic                       valid;
    logic signed [SAMPLE_W-1:0] value;
  } clc_sample_type;
endpackage

// file: dv/clc_limit_checker_test.sv
// testbench of the channel limit checker
// assumes the register port and sample path timing of the design
`timescale 1ns/10ps
module clc_limit_checker_test
  import clc_pkg::*;
();
  logic                       ref_clk_in   = 1'b0;
  logic                       reset_n_in   = 1'b0;
  logic [ADDR_W-1:0]          addr_in      = '0;
  logic [DATA_W-1:0]          wr_data_in   = '0;
  logic                       wr_in        = 1'b0;
  logic                       rd_in        = 1'b0;
  logic                       initiated_in = 1'b0;
  logic                       start_req    = 1'b0;
  logic                       put_smp      = 1'b0;
  logic [1:0]                 put_ch       = 2'h0;
  logic signed [SAMPLE_W-1:0] put_level    = '0;
  logic                       measure_start;
  clc_sample_type [NCH-1:0]   samples;
  logic [DATA_W-1:0]          rd_data_out;
  logic [NCH-1:0]             fail_out;
  logic [QUES_W-1:0]          ques_status_out;
  int                         fails        = 0;
  int                         tests_run    = 0;

  always #4 ref_clk_in = ~ref_clk_in;

  clc_sample_path clc_sample_path_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .start_req_in(start_req), .put_in(put_smp), .chan_in(put_ch), .level_in(put_level),
    .measure_start_out(measure_start), .samples_out(samples));

  clc_limit_checker clc_limit_checker_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .initiated_in(initiated_in), .measure_start_in(measure_start), .samples_in(samples),
    .rd_data_out(rd_data_out), .fail_out(fail_out), .ques_status_out(ques_status_out));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [1:0] ch, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= {idx, ch};
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask

  task automatic rd(input string what, input logic [3:0] idx, input logic [1:0] ch, input logic [31:0] exp);
    @(posedge ref_clk_in);
    addr_in <= {idx, ch};
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    chk(what, exp, rd_data_out);
  endtask

  // read the error bits, then clear them
  task automatic err(input logic [2:0] exp);
    rd("error bits", REG_ERROR, 2'h0, {29'h0, exp});
    wr(REG_ERROR, 2'h0, 32'h00000007);
  endtask

  task automatic smp(input logic [1:0] ch, input logic signed [15:0] v, input logic ok,
                     input logic [3:0] exp);
    @(posedge ref_clk_in);
    put_ch <= ch;
    put_level <= v;
    put_smp <= ok;
    @(posedge ref_clk_in);
    put_smp <= 1'b0;
    #1;
    chk("fail flags", {28'h0, exp}, {28'h0, fail_out});
  endtask

  task automatic start;
    @(posedge ref_clk_in);
    start_req <= 1'b1;
    @(posedge ref_clk_in);
    start_req <= 1'b0;
    #1;
    chk("fail after start", 32'h0, {28'h0, fail_out});
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    rd("lower data", REG_LOWER_DATA, 2'h0, 32'hffffff81);
    rd("upper data", REG_UPPER_DATA, 2'h3, 32'h0000007e);
    rd("lower en", REG_LOWER_EN, 2'h1, 32'h0);
    rd("upper en", REG_UPPER_EN, 2'h2, 32'h0);
    rd("lower bounds", REG_LOWER_LIM, 2'h0, 32'h00007e81);
    rd("upper bounds", REG_UPPER_LIM, 2'h0, 32'h00007f81);
    rd("range", REG_RANGE, 2'h0, {29'h0, RANGE_RESET});
    wr(4'hc, 2'h0, 32'h0000ffff);
    rd("unmapped", 4'hc, 2'h0, 32'h0);
    wr(REG_LOWER_DATA, 2'h0, {14'h0, OPT_MAX, 16'h0});
    rd("lower max", REG_LOWER_DATA, 2'h0, 32'h0000007e);
    wr(REG_UPPER_DATA, 2'h0, {14'h0, OPT_MAX, 16'h0});
    rd("upper max", REG_UPPER_DATA, 2'h0, 32'h0000007f);
    wr(REG_UPPER_DATA, 2'h0, {14'h0, OPT_MIN, 16'h0});
    rd("upper min", REG_UPPER_DATA, 2'h0, 32'hffffff81);
    // codes one step past the lower max and upper min bounds
    wr(REG_LOWER_DATA, 2'h0, 32'h0000007f);
    rd("lower kept", REG_LOWER_DATA, 2'h0, 32'h0000007e);
    err(3'h1);
    wr(REG_UPPER_DATA, 2'h0, 32'h0000ff80);
    rd("upper kept", REG_UPPER_DATA, 2'h0, 32'hffffff81);
    err(3'h1);
    // initiated: values refused, enables taken
    @(posedge ref_clk_in);
    initiated_in <= 1'b1;
    wr(REG_LOWER_DATA, 2'h0, 32'h00000010);
    rd("busy kept", REG_LOWER_DATA, 2'h0, 32'h0000007e);
    err(3'h4);
    wr(REG_UPPER_DATA, 2'h0, 32'h00000010);
    rd("busy upper kept", REG_UPPER_DATA, 2'h0, 32'hffffff81);
    err(3'h4);
    wr(REG_LOWER_EN, 2'h0, 32'h1);
    rd("en while busy", REG_LOWER_EN, 2'h0, 32'h1);
    @(posedge ref_clk_in);
    initiated_in <= 1'b0;
    wr(REG_LOWER_DATA, 2'h0, 32'h00000010);
    wr(REG_UPPER_DATA, 2'h2, 32'h00000020);
    rd("lower set", REG_LOWER_DATA, 2'h0, 32'h00000010);
    // one direction at a time
    wr(REG_UPPER_EN, 2'h0, 32'h1);
    rd("lower off", REG_LOWER_EN, 2'h0, 32'h0);
    rd("upper on", REG_UPPER_EN, 2'h0, 32'h1);
    wr(REG_LOWER_EN, 2'h0, 32'h1);
    rd("upper off", REG_UPPER_EN, 2'h0, 32'h0);
    wr(REG_UPPER_EN, 2'h2, 32'h1);
    // channel 1 level drives the internal trigger
    wr(REG_TRIG, 2'h0, 32'h2);
    rd("trigger select", REG_TRIG, 2'h0, 32'h2);
    wr(REG_LOWER_EN, 2'h1, 32'h1);
    rd("conflict lower", REG_LOWER_EN, 2'h1, 32'h0);
    err(3'h2);
    wr(REG_UPPER_EN, 2'h1, 32'h1);
    rd("conflict upper", REG_UPPER_EN, 2'h1, 32'h0);
    err(3'h2);
    wr(REG_TRIG, 2'h0, 32'h0);
    wr(REG_RANGE, 2'h0, 32'h3);
    rd("new range", REG_RANGE, 2'h0, 32'h3);
    rd("scaled lower", REG_LOWER_DATA, 2'h0, 32'h00000010);
    // measurements: ch0 lower at 0x1000, ch2 upper at 0x2000
    wr(REG_QUES_MASK, 2'h0, 32'h00000600);
    rd("ques mask", REG_QUES_MASK, 2'h0, 32'h00000600);
    start();
    smp(2'h0, 16'sh1000, 1'b1, 4'h0);
    smp(2'h0, 16'sh0fff, 1'b0, 4'h0);
    smp(2'h1, -16'sh7000, 1'b1, 4'h0);
    smp(2'h0, 16'sh0fff, 1'b1, 4'h1);
    @(posedge ref_clk_in);
    #1;
    chk("ques lower", 32'h00000200, {16'h0, ques_status_out});
    smp(2'h0, 16'sh7000, 1'b1, 4'h1);
    rd("fail read", REG_FAIL, 2'h0, 32'h1);
    smp(2'h2, 16'sh2001, 1'b1, 4'h5);
    @(posedge ref_clk_in);
    #1;
    chk("ques both", 32'h00000600, {16'h0, ques_status_out});
    rd("ques reg", REG_QUES, 2'h0, 32'h00000600);
    start();
    rd("fail cleared", REG_FAIL, 2'h0, 32'h0);
    smp(2'h2, 16'sh2000, 1'b1, 4'h0);
    wr(REG_UPPER_EN, 2'h2, 32'h0);
    rd("upper disabled", REG_UPPER_EN, 2'h2, 32'h0);
    report_and_stop();
  end
endmodule

// file: dv/clc_sample_path.sv
// partner model: digitizer sample path feeding every channel
// assumes the bench drives its requests right after the rising edge
`timescale 1ns/10ps
module clc_sample_path
  import clc_pkg::*;
(
  input  wire logic                       ref_clk_in,
  input  wire logic                       reset_n_in,
  input  wire logic                       start_req_in,
  input  wire logic                       put_in,
  input  wire logic [1:0]                 chan_in,
  input  wire logic signed [SAMPLE_W-1:0] level_in,
  output logic                            measure_start_out,
  output clc_sample_type [NCH-1:0]        samples_out
);
  logic [SAMPLE_W-1:0] junk;
  logic                hit;

  // idle lanes carry a value that changes every cycle
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      junk <= 16'h5a3c;
    end else begin
      junk <= ~junk + 16'h0001;
    end
  end

  always_comb begin
    measure_start_out = start_req_in;
    for (int i = 0; i < NCH; i++) begin
      hit = put_in && (chan_in == 2'(i));
      samples_out[i].valid = hit;
      samples_out[i].value = hit ? level_in : junk;
    end
  end
endmodule

// file: src/clc_chan_check.sv
// per-channel sample compare and fail flag
// assumes samples and measurement start synchronous to ref_clk_in
`timescale 1ns/10ps
module clc_chan_check
  import clc_pkg::*;
(
  input  wire logic                     ref_clk_in,
  input  wire logic                     reset_n_in,
  input  wire logic                     measure_start_in,
  input  wire clc_sample_type           sample_in,
  input  wire logic                     lower_en_in,
  input  wire logic                     upper_en_in,
  input  wire logic signed [CODE_W-1:0] lower_code_in,
  input  wire logic signed [CODE_W-1:0] upper_code_in,
  output logic                          fail_out
);
  logic                       next_fail;
  logic signed [SAMPLE_W-1:0] lower_thr;
  logic signed [SAMPLE_W-1:0] upper_thr;
  logic                       below;
  logic                       above;

  always_comb begin
    lower_thr = SAMPLE_W'(lower_code_in) <<< CODE_SHIFT;
    upper_thr = SAMPLE_W'(upper_code_in) <<< CODE_SHIFT;
    below     = sample_in.valid && lower_en_in && (sample_in.value < lower_thr);
    above     = sample_in.valid && upper_en_in && (sample_in.value > upper_thr);
    next_fail = measure_start_in ? 1'b0 : fail_out;
    if (below || above) begin
      next_fail = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fail_out <= 1'b0;
    end else begin
      fail_out <= next_fail;
    end
  end

  a_fail_clears_start: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    measure_start_in && !sample_in.valid |=> !fail_out)
    else $error("fail flag not cleared at measurement start");
  a_fail_holds_on: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    fail_out && !measure_start_in |=> fail_out)
    else $error("fail flag dropped within a measurement");
  a_lower_crossing_sets: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    sample_in.valid && lower_en_in && (sample_in.value < $signed({lower_code_in, 8'h00})) |=> fail_out)
    else $error("lower crossing did not set fail");
  a_upper_crossing_sets: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    sample_in.valid && upper_en_in && (sample_in.value > $signed({upper_code_in, 8'h00})) |=> fail_out)
    else $error("upper crossing did not set fail");
endmodule

// file: src/clc_limit_checker.sv
// channel limit checker: limit settings, enables, fail flags, status
// assumes a plain register port and synchronous sample inputs
//
// What this block does
// - fail read gives 0 if limit not crossed last measurement, else 1
// - fail flag clears when each new measurement starts, unless a sample crosses an enabled limit in the start cycle
// - lower check on: sample below lower limit sets fail until next measurement
// - upper check on: sample above upper limit sets fail until next measurement
// - lower limit accepts -254..+252 volts, min or max, resets to -254
// - upper limit accepts -254..+254 volts, min or max, resets to +252
// - lower limit held in range steps, step scales by four per range
// - upper limit same steps, bound one step larger than lower
// - limit write beyond the range bound raises an error
// - range change keeps each limit at the same fraction of full scale
// - enabling lower check turns off upper check
// - enabling upper check turns off lower check
// - enable refused with conflict error when channel drives internal trigger
// - lower enable reads 1 on, 0 off, resets off
// - upper enable reads 1 on, 0 off, resets off
// - enables taken while initiated, limit values refused while initiated
// - limit read gives stored value, or min or max bound
// - lower and upper failures show at status bits 9 and 10 when unmasked
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
module clc_limit_checker
  import clc_pkg::*;
(
  input  wire logic                       ref_clk_in,
  input  wire logic                       reset_n_in,
  input  wire logic [ADDR_W-1:0]          addr_in,
  input  wire logic [DATA_W-1:0]          wr_data_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  input  wire logic                       initiated_in,
  input  wire logic                       measure_start_in,
  input  wire clc_sample_type [NCH-1:0]   samples_in,
  output logic [DATA_W-1:0]               rd_data_out,
  output logic [NCH-1:0]                  fail_out,
  output logic [QUES_W-1:0]               ques_status_out
);
  logic [NCH-1:0][CODE_W-1:0]  lower_code;
  logic [NCH-1:0][CODE_W-1:0]  upper_code;
  logic [NCH-1:0]              lower_check_enable;
  logic [NCH-1:0]              upper_check_enable;
  logic [NCH-1:0][RANGE_W-1:0] range_sel;
  logic [TRIG_W-1:0]           trigger_origin_select;
  logic [ERR_W-1:0]            err;
  logic [QUES_W-1:0]           ques_mask;

  logic [NCH-1:0][CODE_W-1:0]  next_lower_code;
  logic [NCH-1:0][CODE_W-1:0]  next_upper_code;
  logic [NCH-1:0]              next_lower_check_enable;
  logic [NCH-1:0]              next_upper_check_enable;
  logic [NCH-1:0][RANGE_W-1:0] next_range_sel;
  logic [TRIG_W-1:0]           next_trigger_origin_select;
  logic [ERR_W-1:0]            next_err;
  logic [QUES_W-1:0]           next_ques_mask;
  logic [DATA_W-1:0]           next_rd_data;
  logic [QUES_W-1:0]           next_ques_status;

  logic [3:0]                  reg_sel;
  logic [1:0]                  ch;
  logic signed [CODE_W-1:0]    eval_lower_code;
  logic signed [CODE_W-1:0]    eval_upper_code;
  logic                        eval_lower_ok;
  logic                        eval_upper_ok;
  logic                        channel_level_trigger_source;
  logic [NCH-1:0]              lower_fail;
  logic [NCH-1:0]              upper_fail;

  assign reg_sel = addr_in[ADDR_W-1:2];
  assign ch      = addr_in[1:0];
  // the addressed channel's level is the internal trigger source
  assign channel_level_trigger_source = (trigger_origin_select == TRIG_W'({1'b0, ch} + 3'h1));

  clc_limit_eval u_lower_eval (
    .wr_data_in (wr_data_in),
    .upper_in   (1'b0),
    .code_out   (eval_lower_code),
    .ok_out     (eval_lower_ok)
  );

  clc_limit_eval u_upper_eval (
    .wr_data_in (wr_data_in),
    .upper_in   (1'b1),
    .code_out   (eval_upper_code),
    .ok_out     (eval_upper_ok)
  );

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      clc_chan_check u_check (
        .ref_clk_in       (ref_clk_in),
        .reset_n_in       (reset_n_in),
        .measure_start_in (measure_start_in),
        .sample_in        (samples_in[g]),
        .lower_en_in      (lower_check_enable[g]),
        .upper_en_in      (upper_check_enable[g]),
        .lower_code_in    (lower_code[g]),
        .upper_code_in    (upper_code[g]),
        .fail_out         (fail_out[g])
      );
      assign lower_fail[g] = fail_out[g] && lower_check_enable[g];
      assign upper_fail[g] = fail_out[g] && upper_check_enable[g];
    end
  endgenerate

  // settings and error flags
  always_comb begin
    next_lower_code            = lower_code;
    next_upper_code            = upper_code;
    next_lower_check_enable    = lower_check_enable;
    next_upper_check_enable    = upper_check_enable;
    next_range_sel             = range_sel;
    next_trigger_origin_select = trigger_origin_select;
    next_ques_mask             = ques_mask;
    next_err                   = err;
    if (wr_in) begin
      unique case (reg_sel)
        REG_LOWER_DATA: begin
          if (initiated_in) begin
            next_err[ERR_BUSY] = 1'b1;
          end else if (!eval_lower_ok) begin
            next_err[ERR_BOUND] = 1'b1;
          end else begin
            next_lower_code[ch] = eval_lower_code;
          end
        end
        REG_UPPER_DATA: begin
          if (initiated_in) begin
            next_err[ERR_BUSY] = 1'b1;
          end else if (!eval_upper_ok) begin
            next_err[ERR_BOUND] = 1'b1;
          end else begin
            next_upper_code[ch] = eval_upper_code;
          end
        end
        REG_LOWER_EN: begin
          if (wr_data_in[0] && channel_level_trigger_source) begin
            next_err[ERR_CONFLICT] = 1'b1;
          end else begin
            next_lower_check_enable[ch] = wr_data_in[0];
            if (wr_data_in[0]) begin
              next_upper_check_enable[ch] = 1'b0;
            end
          end
        end
        REG_UPPER_EN: begin
          if (wr_data_in[0] && channel_level_trigger_source) begin
            next_err[ERR_CONFLICT] = 1'b1;
          end else begin
            next_upper_check_enable[ch] = wr_data_in[0];
            if (wr_data_in[0]) begin
              next_lower_check_enable[ch] = 1'b0;
            end
          end
        end
        // codes stay as steps of full scale, so a new range rescales them
        REG_RANGE:     next_range_sel[ch] = wr_data_in[RANGE_W-1:0];
        REG_TRIG:      next_trigger_origin_select = wr_data_in[TRIG_W-1:0];
        REG_QUES_MASK: next_ques_mask = wr_data_in[QUES_W-1:0];
        REG_ERROR:     next_err = err & ~wr_data_in[ERR_W-1:0];
        default:       next_err = err;
      endcase
    end
  end

  // read port and status
  always_comb begin
    next_rd_data = '0;
    if (rd_in) begin
      unique case (reg_sel)
        REG_LOWER_DATA: next_rd_data = DATA_W'($signed(lower_code[ch]));
        REG_UPPER_DATA: next_rd_data = DATA_W'($signed(upper_code[ch]));
        REG_LOWER_EN:   next_rd_data = DATA_W'(lower_check_enable[ch]);
        REG_UPPER_EN:   next_rd_data = DATA_W'(upper_check_enable[ch]);
        REG_FAIL:       next_rd_data = DATA_W'(fail_out[ch]);
        REG_RANGE:      next_rd_data = DATA_W'(range_sel[ch]);
        REG_LOWER_LIM:  next_rd_data = {16'h0000, LOWER_MAX, LOWER_MIN};
        REG_UPPER_LIM:  next_rd_data = {16'h0000, UPPER_MAX, UPPER_MIN};
        REG_ERROR:      next_rd_data = DATA_W'(err);
        REG_TRIG:       next_rd_data = DATA_W'(trigger_origin_select);
        REG_QUES:       next_rd_data = DATA_W'(ques_status_out);
        REG_QUES_MASK:  next_rd_data = DATA_W'(ques_mask);
        default:        next_rd_data = '0;
      endcase
    end
    next_ques_status                 = '0;
    next_ques_status[QUES_LOWER_BIT] = (|lower_fail) && ques_mask[QUES_LOWER_BIT];
    next_ques_status[QUES_UPPER_BIT] = (|upper_fail) && ques_mask[QUES_UPPER_BIT];
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lower_code            <= {NCH{LOWER_RESET}};
      upper_code            <= {NCH{UPPER_RESET}};
      lower_check_enable    <= '0;
      upper_check_enable    <= '0;
      range_sel             <= {NCH{RANGE_RESET}};
      trigger_origin_select <= TRIG_RESET;
      err                   <= '0;
      ques_mask             <= QUES_MASK_RESET;
      rd_data_out           <= '0;
      ques_status_out       <= '0;
    end else begin
      lower_code            <= next_lower_code;
      upper_code            <= next_upper_code;
      lower_check_enable    <= next_lower_check_enable;
      upper_check_enable    <= next_upper_check_enable;
      range_sel             <= next_range_sel;
      trigger_origin_select <= next_trigger_origin_select;
      err                   <= next_err;
      ques_mask             <= next_ques_mask;
      rd_data_out           <= next_rd_data;
      ques_status_out       <= next_ques_status;
    end
  end

  a_enables_exclusive: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (lower_check_enable & upper_check_enable) == '0)
    else $error("both limit checks enabled on one channel");
  a_lower_on_drops_upper: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_in && reg_sel == REG_LOWER_EN && wr_data_in[0] && !channel_level_trigger_source
    |=> lower_check_enable[$past(ch)] && !upper_check_enable[$past(ch)])
    else $error("lower enable did not displace upper");
  a_conflict_refused: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_in && (reg_sel == REG_LOWER_EN || reg_sel == REG_UPPER_EN) && wr_data_in[0] && channel_level_trigger_source
    |=> err[ERR_CONFLICT] && $stable(lower_check_enable) && $stable(upper_check_enable))
    else $error("trigger conflict not refused");
  a_busy_keeps_limits: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_in && (reg_sel == REG_LOWER_DATA || reg_sel == REG_UPPER_DATA) && initiated_in
    |=> err[ERR_BUSY] && $stable(lower_code) && $stable(upper_code))
    else $error("limit changed while initiated");
  a_bound_error_set: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_in && reg_sel == REG_UPPER_DATA && !initiated_in && !eval_upper_ok
    |=> err[ERR_BOUND] && $stable(upper_code))
    else $error("out of bound limit accepted");
  a_fail_read_data: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    rd_in && reg_sel == REG_FAIL |=> rd_data_out == DATA_W'($past(fail_out[ch])))
    else $error("fail read returned wrong value");

  a_upper_on_drops_lower: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_in && reg_sel == REG_UPPER_EN && wr_data_in[0] && !channel_level_trigger_source
    |=> upper_check_enable[$past(ch)] && !lower_check_enable[$past(ch)])
    else $error("upper enable did not displace lower");

  a_lower_bound_error: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_in && reg_sel == REG_LOWER_DATA && !initiated_in && !eval_lower_ok
    |=> err[ERR_BOUND] && $stable(lower_code))
    else $error("out of bound lower limit accepted");

  a_enable_while_busy: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_in && reg_sel == REG_LOWER_EN && initiated_in && !channel_level_trigger_source
    |=> lower_check_enable[$past(ch)] == $past(wr_data_in[0]))
    else $error("enable refused while initiated");

  a_lower_max_option: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_in && reg_sel == REG_LOWER_DATA && !initiated_in && wr_data_in[OPT_LSB+1:OPT_LSB] == OPT_MAX
    |=> lower_code[$past(ch)] == LOWER_MAX)
    else $error("lower max option not stored");

  a_upper_min_option: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_in && reg_sel == REG_UPPER_DATA && !initiated_in && wr_data_in[OPT_LSB+1:OPT_LSB] == OPT_MIN
    |=> upper_code[$past(ch)] == UPPER_MIN)
    else $error("upper min option not stored");

  a_ques_lower_set: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (|(fail_out & lower_check_enable)) && ques_mask[QUES_LOWER_BIT] |=> ques_status_out[QUES_LOWER_BIT])
    else $error("lower failure missing in status");

  a_ques_upper_set: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (|(fail_out & upper_check_enable)) && ques_mask[QUES_UPPER_BIT] |=> ques_status_out[QUES_UPPER_BIT])
    else $error("upper failure missing in status");

  a_ques_masked_off: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !ques_mask[QUES_LOWER_BIT] && !ques_mask[QUES_UPPER_BIT] |=> ques_status_out == '0)
    else $error("masked status bit set");

  a_read_idle_zero: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !rd_in |=> rd_data_out == '0)
    else $error("read data without a read");

  a_range_keeps_codes: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_in && reg_sel == REG_RANGE |=> $stable(lower_code) && $stable(upper_code))
    else $error("range change altered limit codes");

  a_error_clear: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_in && reg_sel == REG_ERROR |=> (err & $past(wr_data_in[ERR_W-1:0])) == '0)
    else $error("error bits not cleared");

  a_lower_en_read: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    rd_in && reg_sel == REG_LOWER_EN |=> rd_data_out == DATA_W'($past(lower_check_enable[ch])))
    else $error("lower enable read wrong");

  a_upper_en_read: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    rd_in && reg_sel == REG_UPPER_EN |=> rd_data_out == DATA_W'($past(upper_check_enable[ch])))
    else $error("upper enable read wrong");

  a_disable_taken: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_in && reg_sel == REG_UPPER_EN && !wr_data_in[0] |=> !upper_check_enable[$past(ch)])
    else $error("upper disable not taken");

endmodule

// file: src/clc_limit_eval.sv
// decodes a limit write into a code and checks its bound
// assumes write data from the register port
`timescale 1ns/10ps
module clc_limit_eval
  import clc_pkg::*;
(
  input  wire logic [DATA_W-1:0]        wr_data_in,
  input  wire logic                     upper_in,
  output logic signed [CODE_W-1:0]      code_out,
  output logic                          ok_out
);
  logic signed [SAMPLE_W-1:0] value;
  logic signed [CODE_W-1:0]   lo;
  logic signed [CODE_W-1:0]   hi;

  always_comb begin
    value = $signed(wr_data_in[SAMPLE_W-1:0]);
    lo    = upper_in ? UPPER_MIN : LOWER_MIN;
    hi    = upper_in ? UPPER_MAX : LOWER_MAX;
    unique case (wr_data_in[OPT_LSB+1:OPT_LSB])
      OPT_MIN: begin
        code_out = lo;
        ok_out   = 1'b1;
      end
      OPT_MAX: begin
        code_out = hi;
        ok_out   = 1'b1;
      end
      default: begin
        code_out = value[CODE_W-1:0];
        ok_out   = (value >= SAMPLE_W'(lo)) && (value <= SAMPLE_W'(hi));
      end
    endcase
  end
endmodule
